// file: hw/uap_serial_port.sv
// Full-duplex asynchronous serial port with 8-bit and 9-bit frames,
// double-buffered receive, two-entry transmit buffer and private baud timer.
// Assumes processor strobes on clk_sys; serial and oscillator pins are async.
//
// How it works
// [RULE1] Data writes feed transmitter, reads give receive buffer
// [RULE2] Receive buffer holds byte while next shifts
// [RULE3] Done flags cleared only by software writes
// [RULE4] Interrupt raised when enabled and either flag set
// [RULE5] Transmit and private receive timers overflow with reload
// [RULE6] Overflow streams halved to form bit ticks
// [RULE7] Bit rate is timer clock/(256-reload)/2
// [RULE8] Receive timer shares reload, reloads on start
// [RULE9] Timer clock picked from six sources
// [RULE10] Control bit 7 selects 8 or 9 bit
// [RULE11] 8-bit frame: start, eight LSB-first, stop
// [RULE12] 8-bit: stop bit lands in received ninth
// [RULE13] Write starts sending; done flag at stop
// [RULE14] No reception until receive enable set
// [RULE15] 8-bit load needs clear flag, filtered stop high
// [RULE16] Overrun keeps first byte, drops the new one
// [RULE17] 9-bit frame adds ninth bit from control
// [RULE18] 9-bit: ninth stored, stop bit ignored
// [RULE19] 9-bit load needs clear flag, filtered ninth high
// [RULE20] Master marks addresses with ninth bit one
// [RULE21] Filter bit 5 passes only address frames
// [RULE22] Slave software toggles filter around its address
// [RULE23] Falling edge starts frame; bits sampled mid-bit
`default_nettype none

module uap_serial_port
    import uap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire uap_pkg::uap_cpu_req_type cpu_req,
    input wire logic timer_run,
    input wire uap_pkg::uap_clk_src_type clk_select,
    input wire logic [7:0] baud_reload_byte,
    input wire logic ext_osc_in,
    input wire logic baud_timer_ext_input,
    input wire logic serial_rx_pin,
    input wire logic irq_enable,
    output logic serial_tx_pin,
    output logic [7:0] serial_control_reg,
    output logic [7:0] serial_data_buffer,
    output logic [7:0] baud_timer_low_byte,
    output logic tx_buf_ready,
    output logic uart_irq
);
    import uap_pkg::*;

    function automatic logic [3:0] frame_bits(input logic nine);
        return nine ? FRAME_BITS_9 : FRAME_BITS_8;
    endfunction

    // Two-flop synchronisers for rx, oscillator and external timer input
    logic [2:0] pin_async;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    assign pin_async = {baud_timer_ext_input, ext_osc_in, serial_rx_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                sync1[gi] <= reset ? 1'b1 : pin_async[gi];
                sync2[gi] <= reset ? 1'b1 : sync1[gi];
                sync3[gi] <= reset ? 1'b1 : sync2[gi];
            end
        end
    endgenerate
    wire rx_line = sync2[0];
    wire rx_fall = sync3[0] & ~sync2[0];
    wire osc_rise = ~sync3[1] & sync2[1];
    wire ext_fall = sync3[2] & ~sync2[2];

    // Timer clock source
    logic [5:0] pre;
    logic [2:0] osc_div;
    wire [5:0] pre_p1 = pre + 6'h0001;
    wire tick_a = (pre_p1 % DIV_A) == 0;
    wire tick_b = (pre_p1 % DIV_B) == 0;
    wire tick_c = (pre_p1 % DIV_C) == 0;
    wire tick_osc = osc_rise & (osc_div == OSC_DIV_LAST);
    logic tick;
    always_comb begin
        case (clk_select) // RULE9
            SRC_SYS: tick = 1'b1;
            SRC_DIV4: tick = tick_a;
            SRC_DIV12: tick = tick_b;
            SRC_DIV48: tick = tick_c;
            SRC_OSC_DIV8: tick = tick_osc;
            SRC_EXT_PIN: tick = ext_fall;
            default: tick = 1'b0;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        pre <= (reset || pre == PRE_LAST) ? 6'h0000 : pre_p1;
        osc_div <= reset ? 3'h0 : osc_div + {2'h0, osc_rise};
    end

    // Transmit timer and its private receive copy
    logic [7:0] rx_timer;
    logic tx_half;
    logic rx_half;
    logic rx_start;
    wire tx_ovf = timer_run & tick & (baud_timer_low_byte == TIMER_TOP);
    wire rx_ovf = timer_run & tick & (rx_timer == TIMER_TOP);
    wire tx_bit_tick = tx_ovf & tx_half; // RULE6
    wire rx_sample = rx_ovf & ~rx_half; // RULE6 RULE23
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baud_timer_low_byte <= TIMER_RESET;
            tx_half <= 1'b0;
        end else if (timer_run && tick) begin
            baud_timer_low_byte <= tx_ovf ? baud_reload_byte : baud_timer_low_byte + 8'h01; // RULE5 RULE7
            tx_half <= tx_half ^ tx_ovf;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_timer <= TIMER_RESET;
            rx_half <= 1'b0;
        end else if (rx_start) begin
            rx_timer <= baud_reload_byte; // RULE8
            rx_half <= 1'b0;
        end else if (timer_run && tick) begin
            rx_timer <= rx_ovf ? baud_reload_byte : rx_timer + 8'h01; // RULE5 RULE8
            rx_half <= rx_half ^ rx_ovf;
        end
    end

    // Two-entry transmit buffer
    uap_tx_word_type tx_mem [2];
    logic tx_wp;
    logic tx_rp;
    logic [1:0] tx_cnt;
    logic tx_load;
    wire tx_push = cpu_req.data_wr & tx_buf_ready; // RULE1 RULE13
    wire [1:0] next_tx_cnt = tx_cnt + {1'b0, tx_push} - {1'b0, tx_load};
    always_ff @(posedge clk_sys) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= '{ninth: serial_control_reg[CTL_TB8], data: cpu_req.data_wdata};
        end
        if (reset) begin
            tx_wp <= 1'b0;
            tx_rp <= 1'b0;
            tx_cnt <= 2'h0;
            tx_buf_ready <= 1'b0;
        end else begin
            tx_wp <= tx_wp ^ tx_push;
            tx_rp <= tx_rp ^ tx_load;
            tx_cnt <= next_tx_cnt;
            tx_buf_ready <= next_tx_cnt != 2'h2;
        end
    end

    // Transmit shifter
    typedef enum logic {TX_IDLE, TX_SHIFT} uap_tx_state_type;
    uap_tx_state_type tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_left;
    wire mode9 = serial_control_reg[CTL_MODE]; // RULE10
    uap_tx_word_type tx_head;
    assign tx_head = tx_mem[tx_rp];
    assign tx_load = (tx_state == TX_IDLE) & (tx_cnt != 2'h0) & tx_bit_tick;
    wire tx_stop_begin = (tx_state == TX_SHIFT) & tx_bit_tick & (tx_left == 4'h1);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_state <= TX_IDLE;
            tx_shift <= '1;
            tx_left <= 4'h0;
            serial_tx_pin <= 1'b1;
        end else if (tx_load) begin
            serial_tx_pin <= 1'b0;
            tx_shift <= {1'b1, 1'b1, mode9 ? tx_head.ninth : 1'b1, tx_head.data}; // RULE11 RULE17
            tx_left <= frame_bits(mode9) - 4'h1;
            tx_state <= TX_SHIFT;
        end else if (tx_state == TX_SHIFT && tx_bit_tick) begin
            if (tx_left == 4'h0) begin
                tx_state <= TX_IDLE;
            end else begin
                serial_tx_pin <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_left <= tx_left - 4'h1;
            end
        end
    end

    // Receive shifter
    typedef enum logic {RX_IDLE, RX_BITS} uap_rx_state_type;
    uap_rx_state_type rx_state;
    logic [9:0] rx_shift;
    logic [3:0] rx_seen;
    logic rx_done_pulse;
    wire rx_enabled = serial_control_reg[CTL_REN];
    assign rx_start = (rx_state == RX_IDLE) & rx_enabled & timer_run & rx_fall; // RULE14 RULE23
    wire rx_last = rx_sample & (rx_seen == frame_bits(mode9) - 4'h1);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_state <= RX_IDLE;
            rx_shift <= '0;
            rx_seen <= 4'h0;
            rx_done_pulse <= 1'b0;
        end else begin
            rx_done_pulse <= (rx_state == RX_BITS) & rx_last;
            if (rx_start) begin
                rx_state <= RX_BITS;
                rx_seen <= 4'h0;
            end else if (rx_state == RX_BITS && rx_sample) begin
                if (rx_seen == 4'h0 && rx_line) begin
                    rx_state <= RX_IDLE;
                end else if (rx_last) begin
                    rx_state <= RX_IDLE;
                    rx_shift <= {rx_line, rx_shift[9:1]};
                end else begin
                    rx_seen <= rx_seen + 4'h1;
                    if (rx_seen != 4'h0) begin
                        rx_shift <= {rx_line, rx_shift[9:1]};
                    end
                end
            end
        end
    end

    // Frame result and load decision
    wire [7:0] rx_byte = mode9 ? rx_shift[7:0] : rx_shift[8:1];
    wire rx_ninth = mode9 ? rx_shift[8] : rx_shift[9]; // RULE12 RULE18
    wire filter_on = serial_control_reg[CTL_AFE];
    wire rx_flag = serial_control_reg[CTL_RXDONE];
    wire rx_accept = rx_done_pulse & ~rx_flag & (~filter_on | rx_ninth); // RULE15 RULE19 RULE21
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_data_buffer <= 8'h00;
        end else if (rx_accept) begin
            serial_data_buffer <= rx_byte; // RULE2 RULE16
        end
    end

    // Control register: hardware set wins over software clear
    logic [7:0] next_ctrl;
    always_comb begin
        next_ctrl = cpu_req.ctrl_wr ? cpu_req.ctrl_wdata : serial_control_reg; // RULE3
        next_ctrl[CTL_FIXED] = 1'b1;
        if (tx_stop_begin) begin
            next_ctrl[CTL_TXDONE] = 1'b1; // RULE13
        end
        if (rx_accept) begin
            next_ctrl[CTL_RXDONE] = 1'b1;
            next_ctrl[CTL_RB8] = rx_ninth;
        end
    end
    always_ff @(posedge clk_sys) begin
        serial_control_reg <= reset ? CTL_RESET : next_ctrl;
        uart_irq <= ~reset & irq_enable & (next_ctrl[CTL_TXDONE] | next_ctrl[CTL_RXDONE]); // RULE4
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_stop_begin;
        tx_stop_begin ##1 serial_tx_pin;
    endsequence
    property p_tx_done_at_stop;
        tx_stop_begin |=> serial_control_reg[CTL_TXDONE];
    endproperty
    a_tx_done_at_stop: assert property (p_tx_done_at_stop) else $error("tx done not set"); // RULE13
    property p_stop_high;
        tx_stop_begin |-> s_stop_begin;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // RULE11
    property p_start_low;
        tx_load |=> !serial_tx_pin ##0 tx_state == TX_SHIFT;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit missing"); // RULE11
    property p_flag_sticky;
        rx_flag && !(cpu_req.ctrl_wr && !cpu_req.ctrl_wdata[CTL_RXDONE]) |=> rx_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("rx flag lost"); // RULE3
    property p_irq;
        irq_enable && (rx_flag || serial_control_reg[CTL_TXDONE]) && !cpu_req.ctrl_wr
            |=> uart_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // RULE4
    property p_rx_reload;
        rx_start |=> rx_timer == $past(baud_reload_byte) && !rx_half;
    endproperty
    a_rx_reload: assert property (p_rx_reload) else $error("rx timer not reloaded"); // RULE8
    property p_overrun;
        rx_done_pulse && rx_flag |=> $stable(serial_data_buffer);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun overwrote data"); // RULE16
    property p_load;
        rx_done_pulse && !rx_flag && !filter_on |=> rx_flag && serial_data_buffer == $past(rx_byte);
    endproperty
    a_load: assert property (p_load) else $error("frame not loaded"); // RULE15
    property p_filter;
        rx_done_pulse && filter_on && !rx_ninth && !rx_flag && !cpu_req.ctrl_wr |=> !rx_flag;
    endproperty
    a_filter: assert property (p_filter) else $error("filtered frame loaded"); // RULE21
    property p_rx_off;
        rx_state == RX_IDLE && !rx_enabled |=> rx_state == RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx ran while disabled"); // RULE14
    property p_timer_reload;
        tx_ovf |=> baud_timer_low_byte == $past(baud_reload_byte);
    endproperty
    a_timer_reload: assert property (p_timer_reload) else $error("timer reload wrong"); // RULE5

endmodule

`default_nettype wire

// file: inc/uap_pkg.sv
// Package for the asynchronous serial port: control field positions,
// reset values, divider counts, clock source choice and carrier structs.
// Assumes a single system clock domain; pins are synchronised in the block.
`default_nettype none

package uap_pkg;

    // Control register field positions
    localparam int CTL_MODE = 7;
    localparam int CTL_FIXED = 6;
    localparam int CTL_AFE = 5;
    localparam int CTL_REN = 4;
    localparam int CTL_TB8 = 3;
    localparam int CTL_RB8 = 2;
    localparam int CTL_TXDONE = 1;
    localparam int CTL_RXDONE = 0;
    localparam logic [7:0] CTL_RESET = 8'h0040;

    // Baud timer
    localparam logic [7:0] TIMER_RESET = 8'h0000;
    localparam logic [7:0] TIMER_TOP = 8'h00ff;
    localparam logic [5:0] PRE_LAST = 6'h002f;
    localparam int DIV_A = 4;
    localparam int DIV_B = 12;
    localparam int DIV_C = 48;
    localparam logic [2:0] OSC_DIV_LAST = 3'h7;

    // Frame lengths including start and stop
    localparam logic [3:0] FRAME_BITS_8 = 4'h000a;
    localparam logic [3:0] FRAME_BITS_9 = 4'h000b;

    typedef enum logic [2:0] {
        SRC_SYS,
        SRC_DIV4,
        SRC_DIV12,
        SRC_DIV48,
        SRC_OSC_DIV8,
        SRC_EXT_PIN
    } uap_clk_src_type;

    // One-cycle register accesses from the processor
    typedef struct packed {
        logic ctrl_wr;
        logic [7:0] ctrl_wdata;
        logic data_wr;
        logic [7:0] data_wdata;
    } uap_cpu_req_type;

    // Word held in the transmit buffer
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } uap_tx_word_type;

endpackage

`default_nettype wire

// file: tb/uap_remote.sv
// Remote serial partner: drives frames onto the receive line and decodes
// frames from the transmit line. Assumes idle-high lines; bit time in cycles.
`default_nettype none

module uap_remote (
    input wire logic clk_sys,
    input wire logic serial_tx_pin,
    output logic serial_rx_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_cyc = 16;
    initial serial_rx_pin = 1'b1;

    task automatic drive_bit(input logic b);
        serial_rx_pin <= b;
        repeat (bit_cyc) @(posedge clk_sys);
    endtask

    // Line returns to its idle high level once the stop bit is over
    task automatic send_frame(input logic [7:0] d, input logic nine, input logic b9,
                              input logic stp);
        drive_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            drive_bit(d[i]);
        end
        if (nine) begin
            drive_bit(b9);
        end
        drive_bit(stp);
        serial_rx_pin <= 1'b1;
    endtask

    // Samples mid-bit on falling clock edges; returns in the stop bit
    task automatic grab_frame(input logic nine, output logic [7:0] d, output logic b9,
                              output logic stp, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b9 = 1'b0;
        d = 8'h0000;
        stp = 1'b0;
        while (serial_tx_pin !== 1'b0 && n < 8000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 8000) begin
            return;
        end
        repeat (bit_cyc / 2) @(negedge clk_sys);
        ok = (serial_tx_pin === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(negedge clk_sys);
            d[i] = serial_tx_pin;
        end
        if (nine) begin
            repeat (bit_cyc) @(negedge clk_sys);
            b9 = serial_tx_pin;
        end
        repeat (bit_cyc) @(negedge clk_sys);
        stp = serial_tx_pin;
    endtask
endmodule

`default_nettype wire

// file: tb/uap_serial_port_tb.sv
// Self-checking bench for the serial port: reset state, clock sources,
// transmit buffering, reception, filtering and overrun. Uses uap_remote.
`default_nettype none

module uap_serial_port_tb
    import uap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    uap_cpu_req_type cpu_req = '0;
    logic timer_run = 1'b1;
    uap_clk_src_type clk_select = SRC_SYS;
    logic [7:0] baud_reload_byte = 8'h00f8;
    logic ext_osc_in = 1'b0;
    logic baud_timer_ext_input = 1'b0;
    logic irq_enable = 1'b1;
    logic serial_rx_pin, serial_tx_pin, tx_buf_ready, uart_irq;
    logic [7:0] serial_control_reg, serial_data_buffer;
    logic [7:0] timer_low;
    logic [1:0] osc_phase = 2'h0;
    int fail_count = 0;
    int checks_done = 0;
    wire logic rx_done = serial_control_reg[CTL_RXDONE];
    wire logic tx_done = serial_control_reg[CTL_TXDONE];
    wire logic rx_ninth = serial_control_reg[CTL_RB8];
    logic [7:0] d;
    logic b9, stp, ok;

    always #50 clk_sys = ~clk_sys;

    // Slow pins for the oscillator and external timer sources: one high cycle in every 3 cycles
    always @(posedge clk_sys) begin
        osc_phase <= (osc_phase == 2'h2) ? 2'h0 : osc_phase + 2'h1;
        ext_osc_in <= (osc_phase == 2'h0);
        baud_timer_ext_input <= ext_osc_in;
    end

    uap_serial_port u_uap_serial_port (.clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req),
        .timer_run(timer_run), .clk_select(clk_select), .baud_reload_byte(baud_reload_byte),
        .ext_osc_in(ext_osc_in), .baud_timer_ext_input(baud_timer_ext_input),
        .serial_rx_pin(serial_rx_pin), .irq_enable(irq_enable), .serial_tx_pin(serial_tx_pin),
        .serial_control_reg(serial_control_reg), .serial_data_buffer(serial_data_buffer),
        .baud_timer_low_byte(timer_low), .tx_buf_ready(tx_buf_ready), .uart_irq(uart_irq));
    uap_remote u_uap_remote (.clk_sys(clk_sys), .serial_tx_pin(serial_tx_pin),
        .serial_rx_pin(serial_rx_pin));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ctl(input logic m, input logic f, input logic r,
                                       input logic t);
        return {m, 1'b0, f, r, t, 3'b000};
    endfunction

    task automatic wr_ctl(input logic [7:0] v);
        @(posedge clk_sys);
        cpu_req.ctrl_wdata <= v;
        cpu_req.ctrl_wr <= 1'b1;
        @(posedge clk_sys);
        cpu_req.ctrl_wr <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wr_data(input logic [7:0] v);
        @(posedge clk_sys);
        cpu_req.data_wdata <= v;
        cpu_req.data_wr <= 1'b1;
        @(posedge clk_sys);
        cpu_req.data_wr <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic rx(input logic [7:0] v, input logic nine, input logic n9, input logic s);
        u_uap_remote.send_frame(v, nine, n9, s);
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_rates();
        uap_clk_src_type src[6] = '{SRC_SYS, SRC_DIV4, SRC_DIV12, SRC_DIV48, SRC_OSC_DIV8,
                                    SRC_EXT_PIN};
        logic [7:0] rl[6] = '{8'h00f8, 8'h00fe, 8'h00ff, 8'h00ff, 8'h00ff, 8'h00fc};
        int bc[6] = '{16, 16, 24, 96, 48, 24};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            clk_select <= src[i];
            baud_reload_byte <= rl[i];
            u_uap_remote.bit_cyc = bc[i];
            wr_data(8'h00a5 ^ 8'(i));
            u_uap_remote.grab_frame(1'b0, d, b9, stp, ok);
            chk({ok, d, stp}, {1'b1, 8'h00a5 ^ 8'(i), 1'b1});
            chk(tx_done, 1);
            repeat (40) @(posedge clk_sys);
            #1;
            chk({tx_done, uart_irq}, 2'b11);
            wr_ctl(ctl(1'b0, 1'b0, 1'b0, 1'b0));
            chk({tx_done, uart_irq}, 2'b00);
        end
        @(posedge clk_sys);
        clk_select <= SRC_SYS;
        baud_reload_byte <= 8'h00f8;
        u_uap_remote.bit_cyc = 16;
        $display("test rates done");
    endtask

    task automatic t_tx9();
        @(posedge clk_sys);
        irq_enable <= 1'b0;
        wr_ctl(ctl(1'b1, 1'b0, 1'b0, 1'b1));
        wr_data(8'h003c);
        u_uap_remote.grab_frame(1'b1, d, b9, stp, ok);
        chk({ok, b9, d, stp, tx_done, uart_irq}, {2'b11, 8'h003c, 2'b11, 1'b0});
        wr_ctl(ctl(1'b1, 1'b0, 1'b0, 1'b0));
        wr_data(8'h00c3);
        u_uap_remote.grab_frame(1'b1, d, b9, stp, ok);
        chk({ok, b9, d, stp}, {2'b10, 8'h00c3, 1'b1});
        @(posedge clk_sys);
        irq_enable <= 1'b1;
        wr_ctl(ctl(1'b0, 1'b0, 1'b0, 1'b0));
        $display("test nine-bit transmit done");
    endtask

    task automatic t_buffer();
        int n;
        n = 0;
        while (tx_buf_ready === 1'b1 && n < 4) begin
            wr_data(8'h0010 + 8'(n));
            n++;
        end
        wr_data(8'h00ee);
        chk(n >= 2, 1);
        for (int i = 0; i < n; i++) begin
            u_uap_remote.grab_frame(1'b0, d, b9, stp, ok);
            chk({ok, d}, {1'b1, 8'h0010 + 8'(i)});
        end
        n = 0;
        repeat (64) begin
            @(negedge clk_sys);
            n += (serial_tx_pin !== 1'b1) ? 1 : 0;
        end
        chk({n == 0, serial_tx_pin, tx_buf_ready}, 3'b111);
        wr_ctl(ctl(1'b0, 1'b0, 1'b0, 1'b0));
        $display("test transmit buffer done");
    endtask

    task automatic t_rx();
        rx(8'h0077, 1'b0, 1'b0, 1'b1);
        chk({rx_done, serial_data_buffer}, 9'h0000);
        wr_ctl(ctl(1'b0, 1'b0, 1'b1, 1'b0));
        rx(8'h005a, 1'b0, 1'b0, 1'b1);
        chk({rx_done, rx_ninth, uart_irq, serial_data_buffer}, 11'h075a);
        fork
            u_uap_remote.send_frame(8'h0042, 1'b0, 1'b0, 1'b1);
            begin
                repeat (80) @(posedge clk_sys);
                #1;
                chk({rx_done, serial_data_buffer}, 9'h015a);
                wr_ctl(ctl(1'b0, 1'b0, 1'b1, 1'b0));
            end
        join
        #1;
        chk({rx_done, serial_data_buffer}, 9'h0142);
        rx(8'h0000, 1'b0, 1'b0, 1'b1);
        chk({rx_done, serial_data_buffer}, 9'h0142);
        wr_ctl(ctl(1'b0, 1'b1, 1'b1, 1'b0));
        rx(8'h0099, 1'b0, 1'b0, 1'b0);
        chk({rx_done, serial_data_buffer}, 9'h0042);
        rx(8'h0066, 1'b0, 1'b0, 1'b1);
        chk({rx_done, rx_ninth, serial_data_buffer}, 10'h0366);
        wr_ctl(ctl(1'b1, 1'b1, 1'b1, 1'b0));
        rx(8'h0024, 1'b1, 1'b0, 1'b1);
        chk({rx_done, serial_data_buffer}, 9'h0066);
        rx(8'h00a1, 1'b1, 1'b1, 1'b0);
        chk({rx_done, rx_ninth, serial_data_buffer}, 10'h03a1);
        wr_ctl(ctl(1'b1, 1'b0, 1'b1, 1'b0));
        rx(8'h0036, 1'b1, 1'b0, 1'b1);
        chk({rx_done, rx_ninth, serial_data_buffer}, 10'h0236);
        $display("test receive done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({serial_control_reg, serial_data_buffer}, {CTL_RESET, 8'h0000});
        chk({serial_tx_pin, tx_buf_ready, uart_irq}, 3'b110);
        chk(timer_low, 8'h0001);
        repeat (260) @(posedge clk_sys);
        #1;
        chk(timer_low, 8'h00fd);
        @(posedge clk_sys);
        timer_run <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(timer_low, 8'h00fe);
        @(posedge clk_sys);
        timer_run <= 1'b1;
        $display("test reset done");
        t_rates();
        t_tx9();
        t_buffer();
        t_rx();
        summarize();
    end
endmodule

`default_nettype wire
